//--- hw/plc_loop_regs.sv
//
// Overview of operation
// - bit 5 of control zero enables reference doubler; resets to 1.
// - pump current field bits 3:0 resets to 8; only codes 4 and 8 supported; any 4-bit code is stored as written.
// - pump phase delay bits 6:4 of control one resets to zero.
// - bit 2 of control one switches in third capacitor; resets to 0.
// - loop resistor two code is a full byte resetting to 0x28.
// - loop capacitor one code bits 2:0 resets to zero.
// - loop resistor three code bits 6:0 resets to zero; bit 7 reserved.
// - loop capacitor three code bits 2:0 resets to zero.
// - nonvolatile contents copied to registers after reset and on load request.
// - register reads are refused while a load copy runs.
// - store request copies registers to nonvolatile shadow; bit self-clears.
//
`timescale 1ns/1ns
module plc_loop_regs (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // register port from serial engine
   input  wire logic       wr_req,
   input  wire logic       rd_req,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] wr_data,
   output logic            rd_valid,
   output logic            rd_refused,
   output logic      [7:0] rd_data,
   // nonvolatile shadow array
   input  wire logic [7:0] nvm_rdata,
   output logic      [2:0] nvm_addr,
   output logic            nvm_we,
   output logic      [7:0] nvm_wdata,
   // loop settings
   output logic            doubler_enable,
   output logic      [3:0] pump_current_code,
   output logic      [2:0] pump_phase_delay,
   output logic            third_cap_enable,
   output logic      [7:0] loop_res_two_code,
   output logic      [2:0] loop_cap_one_code,
   output logic      [6:0] loop_res_three_code,
   output logic      [2:0] loop_cap_three_code
);
   localparam logic [7:0] OFFS [plc_pkg::NUM_REGS] = '{plc_pkg::OFF_REFCLK_PUMP,
      plc_pkg::OFF_PHASE_ORDER, plc_pkg::OFF_RES_TWO, plc_pkg::OFF_CAP_ONE,
      plc_pkg::OFF_RES_THREE, plc_pkg::OFF_CAP_THREE};
   localparam logic [7:0] RSTS [plc_pkg::NUM_REGS] = '{plc_pkg::RST_REFCLK_PUMP,
      plc_pkg::RST_PHASE_ORDER, plc_pkg::RST_RES_TWO, plc_pkg::RST_CAP_ONE,
      plc_pkg::RST_RES_THREE, plc_pkg::RST_CAP_THREE};
   localparam logic [7:0] MSKS [plc_pkg::NUM_REGS] = '{plc_pkg::MSK_REFCLK_PUMP,
      plc_pkg::MSK_PHASE_ORDER, plc_pkg::MSK_RES_TWO, plc_pkg::MSK_CAP_ONE,
      plc_pkg::MSK_RES_THREE, plc_pkg::MSK_CAP_THREE};

   plc_seq_if  sif ();
   logic       rst_q1;
   logic       rst_n;
   logic [7:0] regs [plc_pkg::NUM_REGS];
   logic       busy;
   logic       wr_ok;
   logic       next_rd_valid;
   logic       next_rd_refused;
   logic [7:0] next_rd_data;

   // reset release through two flops
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   plc_nvm_seq u_seq (
      .clock (clock),
      .rst_n (rst_n),
      .sif   (sif)
   );

   assign busy  = sif.loading | sif.storing;
   assign wr_ok = wr_req & ~busy;
   assign sif.load_start  = wr_ok & (reg_addr == plc_pkg::OFF_NVM_CONTROL)
                            & wr_data[plc_pkg::POS_LOAD_REQ];
   assign sif.store_start = wr_ok & (reg_addr == plc_pkg::OFF_NVM_CONTROL)
                            & wr_data[plc_pkg::POS_STORE_REQ];
   assign sif.rd_data = regs[sif.rd_idx];

   // per entry: nonvolatile load wins, else host write; unstored bits stay zero
   for (genvar i = 0; i < plc_pkg::NUM_REGS; i++) begin : g_reg
      logic [7:0] next_val;
      always_comb begin
         next_val = regs[i];
         if (sif.reg_we && (sif.reg_idx == 3'(i))) begin
            next_val = nvm_rdata & MSKS[i];
         end else if (wr_ok && (reg_addr == OFFS[i])) begin
            next_val = wr_data & MSKS[i];
         end
      end
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            regs[i] <= RSTS[i];
         end else begin
            regs[i] <= next_val;
         end
      end
   end

   // read answer, refused during a load copy
   always_comb begin
      next_rd_valid   = rd_req & ~sif.loading;
      next_rd_refused = rd_req & sif.loading;
      next_rd_data    = 8'h00;
      for (int j = 0; j < plc_pkg::NUM_REGS; j++) begin
         if (reg_addr == OFFS[j]) begin
            next_rd_data = regs[j];
         end
      end
      if (reg_addr == plc_pkg::OFF_NVM_CONTROL) begin
         next_rd_data[plc_pkg::POS_STORE_REQ] = sif.storing;
         next_rd_data[plc_pkg::POS_LOAD_REQ]  = sif.loading;
      end
      if (!next_rd_valid) begin
         next_rd_data = rd_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid   <= 1'b0;
         rd_refused <= 1'b0;
         rd_data    <= 8'h00;
      end else begin
         rd_valid   <= next_rd_valid;
         rd_refused <= next_rd_refused;
         rd_data    <= next_rd_data;
      end
   end

   // settings straight from the register flops
   assign doubler_enable      = regs[0][plc_pkg::POS_DOUBLER];
   assign pump_current_code   = regs[0][3:0];
   assign pump_phase_delay    = regs[1][6:4];
   assign third_cap_enable    = regs[1][plc_pkg::POS_THIRD_CAP];
   assign loop_res_two_code   = regs[2];
   assign loop_cap_one_code   = regs[3][2:0];
   assign loop_res_three_code = regs[4][6:0];
   assign loop_cap_three_code = regs[5][2:0];
   assign nvm_addr            = sif.reg_idx;
   assign nvm_we              = sif.nvm_we;
   assign nvm_wdata           = sif.nvm_wdata;

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic wr_idle;
   assign wr_idle = wr_req & ~busy;

   doubler_write_a: assert property (wr_idle && reg_addr == plc_pkg::OFF_REFCLK_PUMP |=>
      doubler_enable == $past(wr_data[plc_pkg::POS_DOUBLER]))
      else $error("doubler enable not updated");
   pump_current_a: assert property (wr_idle && reg_addr == plc_pkg::OFF_REFCLK_PUMP |=>
      pump_current_code == $past(wr_data[3:0]) && !busy)
      else $error("pump current not updated");
   phase_delay_a: assert property (wr_idle && reg_addr == plc_pkg::OFF_PHASE_ORDER |=>
      pump_phase_delay == $past(wr_data[6:4]))
      else $error("phase delay not updated");
   filter_order_a: assert property (wr_idle && reg_addr == plc_pkg::OFF_PHASE_ORDER |=>
      third_cap_enable == $past(wr_data[2]))
      else $error("filter order not updated");
   res_two_a: assert property (wr_idle && reg_addr == plc_pkg::OFF_RES_TWO && !rd_req |=>
      loop_res_two_code == $past(wr_data) && !busy)
      else $error("resistor two not updated");
   cap_one_a: assert property (wr_idle && reg_addr == plc_pkg::OFF_CAP_ONE |=>
      loop_cap_one_code == $past(wr_data[2:0]))
      else $error("capacitor one not updated");
   res_three_read_a: assert property (rd_req && !sif.loading &&
      reg_addr == plc_pkg::OFF_RES_THREE |=> rd_valid && !rd_data[7] &&
      rd_data[6:0] == $past(loop_res_three_code))
      else $error("resistor three read wrong");
   cap_three_a: assert property (wr_idle && reg_addr == plc_pkg::OFF_CAP_THREE |=>
      loop_cap_three_code == $past(wr_data[2:0]))
      else $error("capacitor three not updated");
   load_copy_a: assert property (sif.load_start |=> sif.loading[*6] ##1 !sif.loading)
      else $error("load copy length wrong");
   read_refuse_a: assert property (rd_req && sif.loading |=> rd_refused && !rd_valid)
      else $error("read not refused during load");
   store_copy_a: assert property (sif.store_start && !sif.load_start |=>
      (nvm_we && nvm_wdata == regs[nvm_addr])[*6] ##1 !nvm_we)
      else $error("store copy wrong");

   // copy sequencer and read path
   load_end_a: assert property (sif.loading && nvm_addr == plc_pkg::LAST_IDX |=>
      !busy)
      else $error("load copy did not end");
   load_walk_a: assert property ($past(rst_n) && sif.loading &&
      nvm_addr != plc_pkg::LAST_IDX |=>
      sif.loading && nvm_addr == $past(nvm_addr) + 3'h1)
      else $error("load index did not advance");
   refused_data_a: assert property (rd_refused |-> $stable(rd_data))
      else $error("read data changed on refusal");
   read_taken_a: assert property (rd_req && !sif.loading |=> rd_valid && !rd_refused)
      else $error("read not answered");
   store_strobe_a: assert property (nvm_we == sif.storing)
      else $error("store strobe out of step");
   store_done_a: assert property (sif.storing && nvm_addr == plc_pkg::LAST_IDX |=>
      !sif.storing && !nvm_we)
      else $error("store copy did not end");
   store_freeze_a: assert property (wr_req && sif.storing |=>
      $stable(pump_current_code) && $stable(loop_res_two_code) && $stable(loop_cap_one_code))
      else $error("register changed during store");
   read_zero_a: assert property (rd_req && !sif.loading &&
      reg_addr == plc_pkg::OFF_CAP_ONE |=> rd_data[7:3] == 5'h00)
      else $error("unstored bits read nonzero");

   load_seen_c:    cover property (sif.load_start ##7 rd_valid);
   store_seen_c:   cover property (sif.store_start ##7 !busy);
   refused_seen_c: cover property (rd_refused);
   store_drop_c:   cover property (wr_req && sif.storing);
   store_read_c:   cover property (rd_valid && sif.storing);
endmodule

//--- hw/plc_pkg.sv
package plc_pkg;
   // register offsets
   localparam logic [7:0] OFF_REFCLK_PUMP  = 8'h22;
   localparam logic [7:0] OFF_PHASE_ORDER  = 8'h23;
   localparam logic [7:0] OFF_RES_TWO      = 8'h24;
   localparam logic [7:0] OFF_CAP_ONE      = 8'h25;
   localparam logic [7:0] OFF_RES_THREE    = 8'h26;
   localparam logic [7:0] OFF_CAP_THREE    = 8'h27;
   localparam logic [7:0] OFF_NVM_CONTROL  = 8'h31;
   localparam int         NUM_REGS         = 6;
   localparam logic [2:0] LAST_IDX         = 3'h5;
   // reset values
   localparam logic [7:0] RST_REFCLK_PUMP  = 8'h28;
   localparam logic [7:0] RST_PHASE_ORDER  = 8'h03;
   localparam logic [7:0] RST_RES_TWO      = 8'h28;
   localparam logic [7:0] RST_CAP_ONE      = 8'h00;
   localparam logic [7:0] RST_RES_THREE    = 8'h00;
   localparam logic [7:0] RST_CAP_THREE    = 8'h00;
   // stored bits per register, others read as zero
   localparam logic [7:0] MSK_REFCLK_PUMP  = 8'hef;
   localparam logic [7:0] MSK_PHASE_ORDER  = 8'h77;
   localparam logic [7:0] MSK_RES_TWO      = 8'hff;
   localparam logic [7:0] MSK_CAP_ONE      = 8'h07;
   localparam logic [7:0] MSK_RES_THREE    = 8'h7f;
   localparam logic [7:0] MSK_CAP_THREE    = 8'h07;
   // field positions
   localparam int         POS_DOUBLER      = 5;
   localparam int         POS_THIRD_CAP    = 2;
   localparam int         POS_LOAD_REQ     = 3;
   localparam int         POS_STORE_REQ    = 6;
   // pump current codes
   localparam logic [3:0] PUMP_1P6_MA      = 4'h4;
   localparam logic [3:0] PUMP_6P4_MA      = 4'h8;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_LOAD  = 2'b01,
      SEQ_STORE = 2'b10
   } plc_seq_state_t;
endpackage

//--- hw/plc_seq_if.sv
`timescale 1ns/1ns
interface plc_seq_if;
   logic       load_start;
   logic       store_start;
   logic       loading;
   logic       storing;
   logic       reg_we;
   logic [2:0] reg_idx;
   logic [2:0] rd_idx;
   logic [7:0] rd_data;
   logic       nvm_we;
   logic [7:0] nvm_wdata;

   modport bank (output load_start, output store_start, output rd_data,
                 input loading, input storing, input reg_we, input reg_idx,
                 input rd_idx, input nvm_we, input nvm_wdata);
   modport seq  (input load_start, input store_start, input rd_data,
                 output loading, output storing, output reg_we, output reg_idx,
                 output rd_idx, output nvm_we, output nvm_wdata);
endinterface

//--- hw/plc_nvm_seq.sv
`timescale 1ns/1ns
module plc_nvm_seq (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bank side
   plc_seq_if.seq   sif
);
   plc_pkg::plc_seq_state_t state;
   plc_pkg::plc_seq_state_t next_state;
   logic [2:0]              addr;
   logic [2:0]              next_addr;
   logic                    next_nvm_we;
   logic [7:0]              next_nvm_wdata;

   // copy sequence walks the six entries one per cycle
   always_comb begin
      next_state = state;
      next_addr  = addr;
      case (state)
         plc_pkg::SEQ_IDLE: begin
            if (sif.load_start) begin
               next_state = plc_pkg::SEQ_LOAD;
               next_addr  = 3'h0;
            end else if (sif.store_start) begin
               next_state = plc_pkg::SEQ_STORE;
               next_addr  = 3'h0;
            end
         end
         plc_pkg::SEQ_LOAD, plc_pkg::SEQ_STORE: begin
            if (addr == plc_pkg::LAST_IDX) begin
               next_state = plc_pkg::SEQ_IDLE;
            end else begin
               next_addr = addr + 3'h1;
            end
         end
         default: begin
            next_state = plc_pkg::SEQ_IDLE;
         end
      endcase
      next_nvm_we    = (next_state == plc_pkg::SEQ_STORE);
      next_nvm_wdata = sif.rd_data;
   end

   // reset state is a load, so the bank fills itself after reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state         <= plc_pkg::SEQ_LOAD;
         addr          <= 3'h0;
         sif.nvm_we    <= 1'b0;
         sif.nvm_wdata <= 8'h00;
      end else begin
         state         <= next_state;
         addr          <= next_addr;
         sif.nvm_we    <= next_nvm_we;
         sif.nvm_wdata <= next_nvm_wdata;
      end
   end

   assign sif.loading = (state == plc_pkg::SEQ_LOAD);
   assign sif.storing = (state == plc_pkg::SEQ_STORE);
   assign sif.reg_we  = (state == plc_pkg::SEQ_LOAD);
   assign sif.reg_idx = addr;
   assign sif.rd_idx  = next_addr;
endmodule

//--- bench/tb_pll_loop_config_regs.sv
`timescale 1ns/1ns
module tb_pll_loop_config_regs;
   logic       clock;
   logic       nrst;
   logic       wr_req;
   logic       rd_req;
   logic [7:0] reg_addr;
   logic [7:0] wr_data;
   logic       rd_valid;
   logic       rd_refused;
   logic [7:0] rd_data;
   logic [7:0] nvm_rdata;
   logic [2:0] nvm_addr;
   logic       nvm_we;
   logic [7:0] nvm_wdata;
   logic       doubler_enable;
   logic [3:0] pump_current_code;
   logic [2:0] pump_phase_delay;
   logic       third_cap_enable;
   logic [7:0] loop_res_two_code;
   logic [2:0] loop_cap_one_code;
   logic [6:0] loop_res_three_code;
   logic [2:0] loop_cap_three_code;
   logic [7:0] shadow [0:5];
   logic [7:0] msk    [0:5];
   logic [7:0] wdat   [0:5];
   logic [7:0] ev     [0:5];
   int         err_total;
   int         checks_done;

   plc_loop_regs uut (
      .clock(clock), .nrst(nrst), .wr_req(wr_req), .rd_req(rd_req), .reg_addr(reg_addr),
      .wr_data(wr_data), .rd_valid(rd_valid), .rd_refused(rd_refused), .rd_data(rd_data),
      .nvm_rdata(nvm_rdata), .nvm_addr(nvm_addr), .nvm_we(nvm_we), .nvm_wdata(nvm_wdata),
      .doubler_enable(doubler_enable), .pump_current_code(pump_current_code),
      .pump_phase_delay(pump_phase_delay), .third_cap_enable(third_cap_enable),
      .loop_res_two_code(loop_res_two_code), .loop_cap_one_code(loop_cap_one_code),
      .loop_res_three_code(loop_res_three_code), .loop_cap_three_code(loop_cap_three_code)
   );

   // shadow array: combinational read, written on the store strobe
   assign nvm_rdata = shadow[nvm_addr];
   always @(posedge clock) begin
      if (nvm_we === 1'b1) begin
         shadow[nvm_addr] <= nvm_wdata;
      end
   end

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr_req <= 1'b1;
      reg_addr <= a;
      wr_data <= d;
      @(posedge clock);
      wr_req <= 1'b0;
      #1;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp, input logic refused);
      @(posedge clock);
      rd_req <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      rd_req <= 1'b0;
      #1;
      chk({7'h00, rd_refused}, {7'h00, refused});
      chk({7'h00, rd_valid}, {7'h00, ~refused});
      if (!refused) begin
         chk(rd_data, exp);
      end
   endtask

   task chk_fields;
      chk({7'h00, doubler_enable}, {7'h00, ev[0][5]});
      chk({4'h0, pump_current_code}, {4'h0, ev[0][3:0]});
      chk({5'h00, pump_phase_delay}, {5'h00, ev[1][6:4]});
      chk({7'h00, third_cap_enable}, {7'h00, ev[1][2]});
      chk(loop_res_two_code, ev[2]);
      chk({5'h00, loop_cap_one_code}, {5'h00, ev[3][2:0]});
      chk({1'b0, loop_res_three_code}, {1'b0, ev[4][6:0]});
      chk({5'h00, loop_cap_three_code}, {5'h00, ev[5][2:0]});
   endtask

   task rd_all;
      for (int k = 0; k < 6; k++) begin
         rd(plc_pkg::OFF_REFCLK_PUMP + 8'(k), ev[k], 1'b0);
      end
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(400 * 100);
      err_total++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      test_done;
   end

   initial begin
      nrst = 1'b0;
      wr_req = 1'b0;
      rd_req = 1'b0;
      reg_addr = 8'h00;
      wr_data = 8'h00;
      err_total = 0;
      checks_done = 0;
      shadow = '{8'hd4, 8'hfe, 8'h30, 8'hfb, 8'h94, 8'hae};
      wdat = '{8'h14, 8'h53, 8'h40, 8'hff, 8'hff, 8'hff};
      msk = '{plc_pkg::MSK_REFCLK_PUMP, plc_pkg::MSK_PHASE_ORDER, plc_pkg::MSK_RES_TWO,
              plc_pkg::MSK_CAP_ONE, plc_pkg::MSK_RES_THREE, plc_pkg::MSK_CAP_THREE};
      ev = '{plc_pkg::RST_REFCLK_PUMP, plc_pkg::RST_PHASE_ORDER, plc_pkg::RST_RES_TWO,
             plc_pkg::RST_CAP_ONE, plc_pkg::RST_RES_THREE, plc_pkg::RST_CAP_THREE};
      repeat (12) @(posedge clock);
      chk_fields;
      chk({7'h00, nvm_we}, 8'h00);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      rd(plc_pkg::OFF_RES_TWO, 8'h00, 1'b1);
      repeat (8) @(posedge clock);
      for (int k = 0; k < 6; k++) begin
         ev[k] = shadow[k] & msk[k];
      end
      chk_fields;
      rd_all;
      rd(8'h30, 8'h00, 1'b0);
      for (int k = 0; k < 6; k++) begin
         wr(plc_pkg::OFF_REFCLK_PUMP + 8'(k), wdat[k]);
         ev[k] = wdat[k] & msk[k];
      end
      chk_fields;
      rd_all;
      wr(plc_pkg::OFF_NVM_CONTROL, 8'h40);
      wr(plc_pkg::OFF_CAP_ONE, 8'h05);
      rd(plc_pkg::OFF_NVM_CONTROL, 8'h40, 1'b0);
      repeat (8) @(posedge clock);
      rd(plc_pkg::OFF_NVM_CONTROL, 8'h00, 1'b0);
      for (int k = 0; k < 6; k++) begin
         chk(shadow[k], ev[k]);
      end
      shadow[2] = 8'h01;
      ev[2] = 8'h01;
      wr(plc_pkg::OFF_NVM_CONTROL, 8'h08);
      wr(plc_pkg::OFF_CAP_ONE, 8'h05);
      rd(plc_pkg::OFF_RES_TWO, 8'h00, 1'b1);
      repeat (8) @(posedge clock);
      rd(plc_pkg::OFF_NVM_CONTROL, 8'h00, 1'b0);
      chk_fields;
      rd_all;
      test_done;
   end
endmodule
